// ### core/ebps_defs.vh
// Purpose: constants for the external bus / gpio pin sharing block
// Assumes: included by bare name from core files
// Notes: reset values are per pin group
`ifndef EBPS_DEFS_VH
`define EBPS_DEFS_VH
`define EBPS_PB4_PER_RST 1'h1
`define EBPS_PB4_PUR_RST 1'h1
`define EBPS_CLKO_SEL_RST 1'h0
`define EBPS_PF_PER_RST 4'hF
`define EBPS_PF_PUR_RST 4'hF
`define EBPS_PD_PER_RST 6'h3F
`define EBPS_PD_PUR_RST 6'h3F
`define EBPS_PE0_PER_RST 1'h0
`define EBPS_PE0_PUR_RST 1'h1
`define EBPS_DRV_RST 1'h0
`define EBPS_PD_W 6
`define EBPS_PF_W 4
`endif

// ### core/ebps_pin.v
// Purpose: one shared pin: gpio or alternate function, pull-up, registered
// Assumes: alt_oe already includes any bus-idle release
// Notes: pad input is synchronised by two flops before gpio logic sees it
module ebps_pin (
    input wire clk,
    input wire nrst,
    // config
    input wire gpio_mode,
    input wire pullup_en,
    input wire gpio_dir_out,
    input wire gpio_out,
    // alternate function
    input wire alt_out,
    input wire alt_oe,
    // pad
    input wire pad_in,
    output reg pad_out_r,
    output reg pad_oe_r,
    output reg pad_pu_r,
    output reg gpio_in_r
);
    reg sync1_r;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pad_out_r <= 1'b0;
            pad_oe_r <= 1'b0;
            pad_pu_r <= 1'b1;
            sync1_r <= 1'b0;
            gpio_in_r <= 1'b0;
        end else begin
            pad_out_r <= gpio_mode ? gpio_out : alt_out;
            pad_oe_r <= gpio_mode ? gpio_dir_out : alt_oe;
            // pull-up follows its enable bit alone; a driven pad simply overrides it
            pad_pu_r <= pullup_en;
            sync1_r <= pad_in;
            gpio_in_r <= sync1_r;
        end
    end
endmodule // ebps_pin

// ### core/ebps_top.v
// Purpose: pin sharing for port B4, port F0-3, port D0-5 and port E0
// Assumes: config bits come from logic on clk; pads come from outside
// Notes: every pad output is one flop behind its request
// How it works
// - port b pin4 resets to gpio mode
// - clearing port b pull-up bit 4 removes pin4 pull-up
// - clearing port b peripheral enable bit hands pin4 to alternate function
// - in peripheral mode clock-out select picks address line 20 or prescaled clock
// - clock-out selected drives prescaled clock on pin4
// - address line 20 tri-states on idle bus per drive bit
// - data lines 7 to 10 tri-state on idle bus per drive bit
// - data lines 7 to 10 reset to data bus use
// - clearing port f pull-up bit n removes pin n pull-up
// - each gpio pin has its own direction bit
// - port d pins 0 to 5 reset to gpio mode
// - chip selects come from the memory interface region decode
// - chip selects 2 to 7 tri-state on idle bus per drive bit
// - clearing port d pull-up bit n removes pin n pull-up
// - port e pin0 alternate function is serial 0 transmit
// - port e pin0 resets to serial transmit function
// - clearing port e pull-up bit 0 removes pin0 pull-up
`include "ebps_defs.vh"
module ebps_top #(
    parameter PD_W = `EBPS_PD_W,
    parameter PF_W = `EBPS_PF_W
) (
    input wire clk,
    input wire nrst,
    // port b pin4 configuration
    input wire port_b_peripheral_enable_set,
    input wire port_b_peripheral_enable_clr,
    input wire port_b_pullup_enable_wr,
    input wire port_b_pullup_enable_d,
    input wire clock_out_select_wr,
    input wire clock_out_select_d,
    input wire port_b_dir,
    input wire port_b_out,
    // port f, d, e configuration (write strobe with data)
    input wire cfg_wr,
    input wire [PF_W-1:0] port_f_peripheral_enable_d,
    input wire [PF_W-1:0] port_f_pullup_enable_d,
    input wire [PD_W-1:0] port_d_peripheral_enable_d,
    input wire [PD_W-1:0] port_d_pullup_enable_d,
    input wire port_e_peripheral_enable_d,
    input wire port_e_pullup_enable_d,
    input wire bus_drive_select_d,
    // gpio direction and data
    input wire [PF_W-1:0] port_f_dir,
    input wire [PF_W-1:0] port_f_out,
    input wire [PD_W-1:0] port_d_dir,
    input wire [PD_W-1:0] port_d_out,
    input wire port_e_dir,
    input wire port_e_out,
    // external memory interface and serial channel
    input wire ext_bus_active,
    input wire addr_line_20,
    input wire [PF_W-1:0] ext_data_lines_7_to_10_out,
    input wire ext_data_oe,
    input wire [PD_W-1:0] chip_selects_2_to_7,
    input wire prescaler_clock,
    input wire serial0_transmit,
    // pads
    input wire port_b_pin4_in,
    output wire port_b_pin4_out,
    output wire port_b_pin4_oe,
    output wire port_b_pin4_pu,
    input wire [PF_W-1:0] port_f_pad_in,
    output wire [PF_W-1:0] port_f_pad_out,
    output wire [PF_W-1:0] port_f_pad_oe,
    output wire [PF_W-1:0] port_f_pad_pu,
    input wire [PD_W-1:0] port_d_pad_in,
    output wire [PD_W-1:0] port_d_pad_out,
    output wire [PD_W-1:0] port_d_pad_oe,
    output wire [PD_W-1:0] port_d_pad_pu,
    input wire port_e_pin0_in,
    output wire port_e_pin0_out,
    output wire port_e_pin0_oe,
    output wire port_e_pin0_pu,
    // synchronised gpio inputs and state
    output wire port_b_pin4_gpio_in,
    output wire [PF_W-1:0] port_f_gpio_in,
    output wire [PD_W-1:0] port_d_gpio_in,
    output wire port_e_pin0_gpio_in,
    output reg port_b_gpio_mode_r,
    output reg clock_out_select_r,
    output reg bus_drive_select_r
);
    reg port_b_pullup_r;
    reg [PF_W-1:0] port_f_per_r;
    reg [PF_W-1:0] port_f_pur_r;
    reg [PD_W-1:0] port_d_per_r;
    reg [PD_W-1:0] port_d_pur_r;
    reg port_e_per_r;
    reg port_e_pur_r;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_b_gpio_mode_r <= `EBPS_PB4_PER_RST;
            port_b_pullup_r <= `EBPS_PB4_PUR_RST;
            clock_out_select_r <= `EBPS_CLKO_SEL_RST;
            port_f_per_r <= `EBPS_PF_PER_RST;
            port_f_pur_r <= `EBPS_PF_PUR_RST;
            port_d_per_r <= `EBPS_PD_PER_RST;
            port_d_pur_r <= `EBPS_PD_PUR_RST;
            port_e_per_r <= `EBPS_PE0_PER_RST;
            port_e_pur_r <= `EBPS_PE0_PUR_RST;
            bus_drive_select_r <= `EBPS_DRV_RST;
        end else begin
            // clear wins if both strobes arrive; leaving gpio is the explicit request
            if (port_b_peripheral_enable_clr) begin
                port_b_gpio_mode_r <= 1'b0;
            end else if (port_b_peripheral_enable_set) begin
                port_b_gpio_mode_r <= 1'b1;
            end
            if (port_b_pullup_enable_wr) begin
                port_b_pullup_r <= port_b_pullup_enable_d;
            end
            if (clock_out_select_wr) begin
                clock_out_select_r <= clock_out_select_d;
            end
            if (cfg_wr) begin
                port_f_per_r <= port_f_peripheral_enable_d;
                port_f_pur_r <= port_f_pullup_enable_d;
                port_d_per_r <= port_d_peripheral_enable_d;
                port_d_pur_r <= port_d_pullup_enable_d;
                port_e_per_r <= port_e_peripheral_enable_d;
                port_e_pur_r <= port_e_pullup_enable_d;
                bus_drive_select_r <= bus_drive_select_d;
            end
        end
    end

    // bus pins drive when the bus is busy, or always when drive select is set
    wire bus_drive = ext_bus_active | bus_drive_select_r;
    // clock monitor is not a bus signal, so it ignores bus idle
    wire pb4_alt_out = clock_out_select_r ? prescaler_clock : addr_line_20;
    wire pb4_alt_oe = clock_out_select_r | bus_drive;
    // data lines in bus mode drive only during a write and only when not released
    wire data_oe = ext_data_oe & bus_drive;

    ebps_pin u_pb4 (
        .clk(clk),
        .nrst(nrst),
        .gpio_mode(port_b_gpio_mode_r),
        .pullup_en(port_b_pullup_r),
        .gpio_dir_out(port_b_dir),
        .gpio_out(port_b_out),
        .alt_out(pb4_alt_out),
        .alt_oe(pb4_alt_oe),
        .pad_in(port_b_pin4_in),
        .pad_out_r(port_b_pin4_out),
        .pad_oe_r(port_b_pin4_oe),
        .pad_pu_r(port_b_pin4_pu),
        .gpio_in_r(port_b_pin4_gpio_in)
    );

    genvar i;
    generate
        for (i = 0; i < PF_W; i = i + 1) begin : g_pf
            // peripheral enable set means data bus use
            ebps_pin u_pf (
                .clk(clk),
                .nrst(nrst),
                .gpio_mode(~port_f_per_r[i]),
                .pullup_en(port_f_pur_r[i]),
                .gpio_dir_out(port_f_dir[i]),
                .gpio_out(port_f_out[i]),
                .alt_out(ext_data_lines_7_to_10_out[i]),
                .alt_oe(data_oe),
                .pad_in(port_f_pad_in[i]),
                .pad_out_r(port_f_pad_out[i]),
                .pad_oe_r(port_f_pad_oe[i]),
                .pad_pu_r(port_f_pad_pu[i]),
                .gpio_in_r(port_f_gpio_in[i])
            );
        end
        for (i = 0; i < PD_W; i = i + 1) begin : g_pd
            // peripheral enable set means gpio, matching port b
            ebps_pin u_pd (
                .clk(clk),
                .nrst(nrst),
                .gpio_mode(port_d_per_r[i]),
                .pullup_en(port_d_pur_r[i]),
                .gpio_dir_out(port_d_dir[i]),
                .gpio_out(port_d_out[i]),
                .alt_out(chip_selects_2_to_7[i]),
                .alt_oe(bus_drive),
                .pad_in(port_d_pad_in[i]),
                .pad_out_r(port_d_pad_out[i]),
                .pad_oe_r(port_d_pad_oe[i]),
                .pad_pu_r(port_d_pad_pu[i]),
                .gpio_in_r(port_d_gpio_in[i])
            );
        end
    endgenerate

    // serial transmit is always driven; it is not an external bus signal
    ebps_pin u_pe0 (
        .clk(clk),
        .nrst(nrst),
        .gpio_mode(port_e_per_r),
        .pullup_en(port_e_pur_r),
        .gpio_dir_out(port_e_dir),
        .gpio_out(port_e_out),
        .alt_out(serial0_transmit),
        .alt_oe(1'b1),
        .pad_in(port_e_pin0_in),
        .pad_out_r(port_e_pin0_out),
        .pad_oe_r(port_e_pin0_oe),
        .pad_pu_r(port_e_pin0_pu),
        .gpio_in_r(port_e_pin0_gpio_in)
    );
endmodule // ebps_top

// ### dv/ebps_pad_model.sv
// Purpose: board side of the shared pads: resolves drivers, pull-ups and released lines
// Assumes: one bit per pad, concatenated by the bench
// Notes: a released pad with no pull-up toggles so a stale value never passes as data
module ebps_pad_model #(parameter int W = 12) (
    // clock
    input wire clk,
    // pad requests from the block and from the board
    input wire [W-1:0] pout, poe, ppu, drv_en, drv_val,
    // resolved pad level
    output logic [W-1:0] pad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [W-1:0] last_r;
    always @(posedge clk) last_r <= pad;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pad[i] = poe[i] ? pout[i] : drv_en[i] ? drv_val[i] : ppu[i] ? 1'h1 : ~last_r[i];
        end
    end
endmodule // ebps_pad_model

// ### dv/ebps_top_sva.sv
// Purpose: checks port b pin4 muxing and config loading at the top ports
// Assumes: pads lag their request by one edge
// Notes: pad checks skip the first edge after reset, pads still hold reset values there
module ebps_top_sva (
    // clock and reset
    input wire clk, nrst,
    // config inputs
    input wire port_b_peripheral_enable_set, port_b_peripheral_enable_clr, cfg_wr,
    input wire port_b_pullup_enable_wr, port_b_pullup_enable_d, bus_drive_select_d,
    input wire clock_out_select_wr, clock_out_select_d, port_b_dir, port_b_out,
    // alternate sources
    input wire ext_bus_active, addr_line_20, prescaler_clock,
    // outputs
    input wire port_b_pin4_out, port_b_pin4_oe, port_b_pin4_pu,
    input wire port_b_gpio_mode_r, clock_out_select_r, bus_drive_select_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_clr_wins: assert property (port_b_peripheral_enable_clr |=> !port_b_gpio_mode_r)
        else $error("pin4 not handed to peripheral");
    a_set_gpio: assert property (port_b_peripheral_enable_set &&
        !port_b_peripheral_enable_clr |=> port_b_gpio_mode_r) else $error("pin4 not back in gpio");
    a_cos_load: assert property (clock_out_select_wr |=>
        clock_out_select_r == $past(clock_out_select_d)) else $error("clock select not loaded");
    a_drive_load: assert property (cfg_wr |=>
        bus_drive_select_r == $past(bus_drive_select_d)) else $error("drive bit not loaded");
    a_pb4_gpio_pad: assert property ($past(nrst) && $past(port_b_gpio_mode_r) |->
        port_b_pin4_oe == $past(port_b_dir) && port_b_pin4_out == $past(port_b_out))
        else $error("pin4 gpio pad wrong");
    a_pb4_addr_pad: assert property ($past(nrst) && !$past(port_b_gpio_mode_r) &&
        !$past(clock_out_select_r) |-> port_b_pin4_out == $past(addr_line_20) &&
        port_b_pin4_oe == ($past(ext_bus_active) | $past(bus_drive_select_r)))
        else $error("pin4 address pad wrong");
    a_pb4_clk_pad: assert property ($past(nrst) && !$past(port_b_gpio_mode_r) &&
        $past(clock_out_select_r) |-> port_b_pin4_oe && port_b_pin4_out == $past(prescaler_clock))
        else $error("pin4 clock pad wrong");
    a_pb4_pull: assert property (port_b_pullup_enable_wr |-> ##2
        port_b_pin4_pu == $past(port_b_pullup_enable_d, 2)) else $error("pin4 pull-up wrong");
    cover property (port_b_peripheral_enable_set && port_b_peripheral_enable_clr);
    cover property (!port_b_gpio_mode_r && clock_out_select_r);
    cover property (!port_b_gpio_mode_r && !ext_bus_active && bus_drive_select_r);
endmodule // ebps_top_sva
bind ebps_top ebps_top_sva chk_u (.*);

// ### dv/ebps_bench.sv
// Purpose: self-checking bench for the pin sharing block
// Assumes: inputs change on the falling edge
// Notes: pb4 mode rows first, then reset and port f/d/e cases
module ebps_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, nrst = 1'h0, cfg_wr = 1'h0, ext_bus_active = 1'h0, addr_line_20 = 1'h0;
    logic port_b_peripheral_enable_set = 1'h0, port_b_peripheral_enable_clr = 1'h0;
    logic port_b_pullup_enable_wr = 1'h0, port_b_pullup_enable_d = 1'h1, port_b_dir = 1'h0;
    logic clock_out_select_wr = 1'h0, clock_out_select_d = 1'h0, port_b_out = 1'h0;
    logic port_e_peripheral_enable_d = 1'h0, port_e_pullup_enable_d = 1'h1;
    logic bus_drive_select_d = 1'h0, port_e_dir = 1'h0, port_e_out = 1'h0, ext_data_oe = 1'h1;
    logic prescaler_clock = 1'h0, serial0_transmit = 1'h1;
    logic [3:0] port_f_peripheral_enable_d = 4'hF, port_f_pullup_enable_d = 4'hF;
    logic [3:0] port_f_dir = 4'h5, port_f_out = 4'h9, ext_data_lines_7_to_10_out = 4'h6;
    logic [5:0] port_d_peripheral_enable_d = 6'h3F, port_d_pullup_enable_d = 6'h3F;
    logic [5:0] port_d_dir = 6'h2A, port_d_out = 6'h13, chip_selects_2_to_7 = 6'h25;
    logic [11:0] brd_en = 12'h000;
    logic [9:0] r;
    wire port_b_pin4_in, port_b_pin4_out, port_b_pin4_oe, port_b_pin4_pu, port_b_pin4_gpio_in;
    wire port_e_pin0_in, port_e_pin0_out, port_e_pin0_oe, port_e_pin0_pu, port_e_pin0_gpio_in;
    wire [3:0] port_f_pad_in, port_f_pad_out, port_f_pad_oe, port_f_pad_pu, port_f_gpio_in;
    wire [5:0] port_d_pad_in, port_d_pad_out, port_d_pad_oe, port_d_pad_pu, port_d_gpio_in;
    wire port_b_gpio_mode_r, clock_out_select_r, bus_drive_select_r;
    int fails = 0, n_tests = 0;
    // row: gpio, clk sel, bus active, drive, addr, prescaler, dir, out, exp out, exp oe
    localparam logic [9:0] ROWS [6] = '{10'h20F, 10'h280, 10'h0A3, 10'h022, 10'h041, 10'h113};
    ebps_top dut_u (.*);
    ebps_pad_model pads_u (.clk(clk), .drv_en(brd_en), .drv_val(12'h000),
        .pout({port_b_pin4_out, port_f_pad_out, port_d_pad_out, port_e_pin0_out}),
        .poe({port_b_pin4_oe, port_f_pad_oe, port_d_pad_oe, port_e_pin0_oe}),
        .ppu({port_b_pin4_pu, port_f_pad_pu, port_d_pad_pu, port_e_pin0_pu}),
        .pad({port_b_pin4_in, port_f_pad_in, port_d_pad_in, port_e_pin0_in}));
    always #5 clk = ~clk;
    task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #5000;
        fails++;
        tally_and_finish;
    end
    initial begin
        tick(3);
        nrst = 1'h1;
        foreach (ROWS[i]) begin
            r = ROWS[i];
            {ext_bus_active, addr_line_20, prescaler_clock, port_b_dir, port_b_out} = {r[7], r[5:2]};
            {bus_drive_select_d, clock_out_select_d} = {r[6], r[8]};
            {port_b_peripheral_enable_set, port_b_peripheral_enable_clr} = {r[9], ~r[9]};
            {cfg_wr, clock_out_select_wr} = 2'h3;
            tick(1);
            {cfg_wr, clock_out_select_wr} = 2'h0;
            {port_b_peripheral_enable_set, port_b_peripheral_enable_clr} = 2'h0;
            tick(4);
            chk("pb4_pad", {r[1], r[0]}, {port_b_pin4_out, port_b_pin4_oe});
            if (r[9]) chk("pb4_in", r[0] ? r[1] : 1'h1, port_b_pin4_gpio_in);
        end
        {ext_bus_active, bus_drive_select_d, nrst} = 3'h0;
        tick(1);
        chk("rst_oe", 12'h000, {port_b_pin4_oe, port_f_pad_oe, port_d_pad_oe, port_e_pin0_oe});
        nrst = 1'h1;
        tick(2);
        chk("pb4_mode", 12'h001, port_b_gpio_mode_r);
        chk("pd_oe", port_d_dir, port_d_pad_oe);
        chk("pe0", 12'h003, {port_e_pin0_oe, port_e_pin0_out});
        chk("pf_idle", 12'h000, port_f_pad_oe);
        ext_bus_active = 1'h1;
        tick(2);
        chk("pf_bus", 12'h0F6, {port_f_pad_oe, port_f_pad_out});
        {port_f_pullup_enable_d, port_d_pullup_enable_d, port_e_pullup_enable_d} = 11'h77C;
        {port_f_peripheral_enable_d, port_d_peripheral_enable_d} = 10'h000;
        {port_e_peripheral_enable_d, port_b_pullup_enable_d} = 2'h2;
        {cfg_wr, port_b_pullup_enable_wr, brd_en} = {2'h3, 12'h800};
        tick(1);
        {cfg_wr, port_b_pullup_enable_wr} = 2'h0;
        tick(3);
        chk("pu", 12'h77C, {port_b_pin4_pu, port_f_pad_pu, port_d_pad_pu, port_e_pin0_pu});
        chk("pd_cs", 12'hFE5, {port_d_pad_oe, port_d_pad_out});
        chk("gpio_oe", 12'h050, {port_f_pad_oe, port_e_pin0_oe, 3'h0});
        chk("pb4_low", 12'h000, port_b_pin4_gpio_in);
        chk("pf_in", 12'h00B, port_f_gpio_in);
        chk("pd_in", 12'h025, port_d_gpio_in);
        ext_bus_active = 1'h0;
        tick(2);
        chk("pd_rel", 12'h000, port_d_pad_oe);
        {port_b_peripheral_enable_set, port_b_peripheral_enable_clr} = 2'h3;
        tick(1);
        {port_b_peripheral_enable_set, port_b_peripheral_enable_clr} = 2'h0;
        chk("clr_wins", 12'h000, port_b_gpio_mode_r);
        tally_and_finish;
    end
endmodule // ebps_bench
